//--- rtl/rpc_defines.vh
`ifndef RPC_DEFINES_VH
`define RPC_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RPC_OFF_ALGO_SELECT 8'h1c
`define RPC_OFF_CLOCK_RECOVERY 8'h23
`define RPC_OFF_GAIN_TIMING 8'h24
`define RPC_OFF_GAIN_THRESHOLDS 8'h25
`define RPC_OFF_GAIN_ENABLE 8'h26
`define RPC_OFF_ANTENNA_SWITCH 8'h27
`define RPC_OFF_BLOCK_STATUS 8'h2a
`define RPC_OFF_FIELD_LENGTHS 8'h30
`define RPC_OFF_FORMAT_SELECT 8'h31
`define RPC_OFF_PREAMBLE_SYNC 8'h32
`define RPC_OFF_CODING_OPTIONS 8'h33
`define RPC_OFF_LENGTH_HIGH 8'h34
`define RPC_OFF_LENGTH_LOW 8'h35

// ----------------------------------------
// reset values (reserved bits included)
// ----------------------------------------
`define RPC_RST_CLOCK_RECOVERY 8'h58
`define RPC_RST_GAIN_TIMING 8'h22
`define RPC_RST_GAIN_THRESHOLDS 8'h65
`define RPC_RST_GAIN_ENABLE 8'h8a
`define RPC_RST_ANTENNA_SWITCH 8'h05
`define RPC_RST_FIELD_LENGTHS 8'h00
`define RPC_RST_FORMAT_SELECT 8'h07
`define RPC_RST_PREAMBLE_SYNC 8'h1e
`define RPC_RST_CODING_OPTIONS 8'h20
`define RPC_RST_LENGTH_HIGH 8'h00
`define RPC_RST_LENGTH_LOW 8'h14
`define RPC_RST_ALGO_SELECT 1'b0

// ----------------------------------------
// writable bit masks
// ----------------------------------------
`define RPC_WMASK_GAIN_TIMING 8'h0f
`define RPC_WMASK_GAIN_ENABLE 8'h80
`define RPC_WMASK_ANTENNA_SWITCH 8'h1f
`define RPC_WMASK_FIELD_LENGTHS 8'h1f
`define RPC_WMASK_CODING_OPTIONS 8'hfd

// ----------------------------------------
// field positions
// ----------------------------------------
`define RPC_PGAIN_MSB 7
`define RPC_PGAIN_LSB 5
`define RPC_POSTFILTER_BIT 4
`define RPC_IGAIN_MSB 3
`define RPC_IGAIN_LSB 0
`define RPC_ALGO_BIT 3
`define RPC_GAIN_ON_BIT 7
`define RPC_BLANKING_BIT 4
`define RPC_ANT_ON_BIT 3
`define RPC_ADDR_LEN_MSB 4
`define RPC_ADDR_LEN_LSB 3
`define RPC_FORMAT_MSB 7
`define RPC_FORMAT_LSB 6
`define RPC_RX_ROUTE_MSB 5
`define RPC_RX_ROUTE_LSB 4
`define RPC_PREAMBLE_MSB 7
`define RPC_PREAMBLE_LSB 3
`define RPC_SYNC_MSB 2
`define RPC_SYNC_LSB 1
`define RPC_CRC_MSB 7
`define RPC_CRC_LSB 5
`define RPC_SCRAMBLER_BIT 4
`define RPC_TX_SOURCE_MSB 3
`define RPC_TX_SOURCE_LSB 2

// ----------------------------------------
// codes and constants
// ----------------------------------------
`define RPC_POSTFILTER_SHORT 5'd8
`define RPC_POSTFILTER_LONG 5'd16
`define RPC_ALGO_PLL 1'b0
`define RPC_TX_SOURCE_PN9 2'h3
`define RPC_PN9_SEED 9'h1ff
`define RPC_CRC_POLY_8 24'h000007
`define RPC_CRC_POLY_16A 24'h008005
`define RPC_CRC_POLY_16B 24'h001021
`define RPC_CRC_POLY_24 24'h864cbf

`endif

//--- rtl/rpc_pn9.v
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// pn9 sequence source, x^9 + x^5 + 1
// ----------------------------------------
`include "rpc_defines.vh"

module rpc_pn9 (
  input wire sys_clk_in,
  input wire resetn_in,
  input wire enable_in,
  input wire step_in,
  output reg [8:0] state_out
);

  // reseeded while idle so every pn9 burst starts identically
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      state_out <= `RPC_PN9_SEED;
    else if (!enable_in)
      state_out <= `RPC_PN9_SEED;
    else if (step_in)
      state_out <= {state_out[0] ^ state_out[5], state_out[8:1]};
  end

endmodule

`default_nettype wire

//--- rtl/rpc_config_regs.v
// Functional notes
// [R1] proportional recovery gain is a log2 value in bits 7:5, reset 2
// [R2] post-filter spans 8 symbols when bit is 0, 16 when 1; reset 1
// [R3] integral gain bits 3:0 reset 8, applied only in pll mode
// [R4] gain control compares high 0110 and low 0101 thresholds, enable bit 7 set
// [R5] blanking bit stops rx fifo writes while signal below carrier sense
// [R6] antenna switching only when enabled; three-bit window resets to 101
// [R7] address field byte count: 0 or 1 basic, 2 stacked format
// [R8] control field byte count in bits 2:0, reset zero
// [R9] frame format code: 0 basic, 2 metering bus, 3 stacked
// [R10] rx route: 0 packet handling, 1 direct fifo, 2 direct pin
// [R11] length field width in bits, reset 0111, needed for variable length
// [R12] preamble length field gives 1 to 32 bytes, reset 00011
// [R13] sync length field gives 1 to 4 bytes, reset 11
// [R14] length mode bit: 0 fixed length, 1 variable with length field
// [R15] crc code selects none or one of four polynomials, reset code 1
// [R16] whitening on tx and de-whitening on rx only while bit 4 set
// [R17] tx source: packets, direct fifo, direct pin, or pn9 sequence
// [R18] fec bit enables fec encoding on tx and viterbi decoding on rx
// [R19] packet length high byte register, reset zero
// [R20] packet length low byte register at next address, reset 0x14
// [R21] one select bit chooses pll or dll timing recovery, reset 0
// [R22] reserved bits keep their reset values and do nothing
`timescale 1ns/100ps
`default_nettype none

`include "rpc_defines.vh"

module rpc_config_regs (
  input wire sys_clk_in,
  input wire resetn_in,
  input wire [7:0] reg_addr_in,
  input wire reg_wr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  output reg reg_rdata_valid_out,
  input wire [3:0] gain_level_in,
  input wire below_carrier_sense_in,
  input wire rx_data_valid_in,
  input wire tx_bit_strobe_in,
  output wire [2:0] recovery_proportional_gain_out,
  output reg [4:0] recovery_postfilter_span_out,
  output reg [3:0] recovery_integral_gain_out,
  output wire timing_recovery_algorithm_out,
  output wire [3:0] gain_measure_window_out,
  output reg gain_control_on_out,
  output reg gain_above_high_out,
  output reg gain_below_low_out,
  output reg rx_fifo_write_out,
  output reg antenna_switch_on_out,
  output wire [2:0] antenna_measure_window_out,
  output wire [1:0] addr_field_bytes_out,
  output reg stacked_address_out,
  output wire [2:0] ctrl_field_bytes_out,
  output wire [1:0] frame_format_code_out,
  output reg frame_format_legal_out,
  output wire [1:0] rx_route_select_out,
  output wire [3:0] length_field_bits_out,
  output reg [5:0] preamble_bytes_out,
  output reg [2:0] sync_bytes_out,
  output wire length_mode_select_out,
  output reg [23:0] crc_poly_out,
  output reg [4:0] crc_width_out,
  output wire scrambler_on_out,
  output wire [1:0] transmit_source_select_out,
  output reg pn9_bit_out,
  output wire error_correction_on_out,
  output reg [15:0] packet_length_out
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [7:0] clock_recovery_config;
  reg [7:0] gain_control_timing;
  reg [7:0] gain_control_thresholds;
  reg [7:0] gain_control_enable;
  reg [7:0] antenna_switch_config;
  reg [7:0] packet_field_lengths;
  reg [7:0] packet_format_select;
  reg [7:0] preamble_sync_length;
  reg [7:0] packet_coding_options;
  reg [7:0] packet_length_high;
  reg [7:0] packet_length_low;
  reg timing_recovery_algorithm;
  reg [7:0] next_rdata;
  wire [8:0] pn9_state;
  wire pn9_active;
  wire [7:0] block_status;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // reserved bits come from the reset value, writable bits from the bus
  function [7:0] merge_masked;
    input [7:0] wdata;
    input [7:0] mask;
    input [7:0] rst;
    begin
      merge_masked = (wdata & mask) | (rst & ~mask);
    end
  endfunction

  function [23:0] crc_poly_of;
    input [2:0] code;
    begin
      case (code)
        3'h1: crc_poly_of = `RPC_CRC_POLY_8;
        3'h2: crc_poly_of = `RPC_CRC_POLY_16A;
        3'h3: crc_poly_of = `RPC_CRC_POLY_16B;
        3'h4: crc_poly_of = `RPC_CRC_POLY_24;
        default: crc_poly_of = 24'h000000;
      endcase
    end
  endfunction

  function [4:0] crc_width_of;
    input [2:0] code;
    begin
      case (code)
        3'h1: crc_width_of = 5'd8;
        3'h2: crc_width_of = 5'd16;
        3'h3: crc_width_of = 5'd16;
        3'h4: crc_width_of = 5'd24;
        default: crc_width_of = 5'd0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      clock_recovery_config <= `RPC_RST_CLOCK_RECOVERY; // [R1] [R2] [R3]
      gain_control_timing <= `RPC_RST_GAIN_TIMING;
      gain_control_thresholds <= `RPC_RST_GAIN_THRESHOLDS; // [R4]
      gain_control_enable <= `RPC_RST_GAIN_ENABLE; // [R4]
      antenna_switch_config <= `RPC_RST_ANTENNA_SWITCH; // [R5] [R6]
      packet_field_lengths <= `RPC_RST_FIELD_LENGTHS; // [R8]
      packet_format_select <= `RPC_RST_FORMAT_SELECT; // [R11]
      preamble_sync_length <= `RPC_RST_PREAMBLE_SYNC; // [R12] [R13]
      packet_coding_options <= `RPC_RST_CODING_OPTIONS; // [R15]
      packet_length_high <= `RPC_RST_LENGTH_HIGH; // [R19]
      packet_length_low <= `RPC_RST_LENGTH_LOW; // [R20]
      timing_recovery_algorithm <= `RPC_RST_ALGO_SELECT; // [R21]
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == `RPC_OFF_CLOCK_RECOVERY)
        clock_recovery_config <= reg_wdata_in;
      else if (reg_addr_in == `RPC_OFF_GAIN_TIMING)
        gain_control_timing <= merge_masked(reg_wdata_in, `RPC_WMASK_GAIN_TIMING,
          `RPC_RST_GAIN_TIMING); // [R22]
      else if (reg_addr_in == `RPC_OFF_GAIN_THRESHOLDS)
        gain_control_thresholds <= reg_wdata_in;
      else if (reg_addr_in == `RPC_OFF_GAIN_ENABLE)
        gain_control_enable <= merge_masked(reg_wdata_in, `RPC_WMASK_GAIN_ENABLE,
          `RPC_RST_GAIN_ENABLE); // [R22]
      else if (reg_addr_in == `RPC_OFF_ANTENNA_SWITCH)
        antenna_switch_config <= merge_masked(reg_wdata_in, `RPC_WMASK_ANTENNA_SWITCH,
          `RPC_RST_ANTENNA_SWITCH); // [R22]
      else if (reg_addr_in == `RPC_OFF_FIELD_LENGTHS)
        packet_field_lengths <= merge_masked(reg_wdata_in, `RPC_WMASK_FIELD_LENGTHS,
          `RPC_RST_FIELD_LENGTHS); // [R22]
      else if (reg_addr_in == `RPC_OFF_FORMAT_SELECT)
        packet_format_select <= reg_wdata_in;
      else if (reg_addr_in == `RPC_OFF_PREAMBLE_SYNC)
        preamble_sync_length <= reg_wdata_in;
      else if (reg_addr_in == `RPC_OFF_CODING_OPTIONS)
        packet_coding_options <= merge_masked(reg_wdata_in, `RPC_WMASK_CODING_OPTIONS,
          `RPC_RST_CODING_OPTIONS); // [R22]
      else if (reg_addr_in == `RPC_OFF_LENGTH_HIGH)
        packet_length_high <= reg_wdata_in; // [R19]
      else if (reg_addr_in == `RPC_OFF_LENGTH_LOW)
        packet_length_low <= reg_wdata_in; // [R20]
      else if (reg_addr_in == `RPC_OFF_ALGO_SELECT)
        timing_recovery_algorithm <= reg_wdata_in[`RPC_ALGO_BIT]; // [R21]
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  assign block_status = {rx_fifo_write_out, gain_above_high_out, gain_below_low_out,
    antenna_switch_on_out, pn9_bit_out, frame_format_legal_out, 2'h0};

  always @*
  begin
    next_rdata = 8'h00;
    if (reg_addr_in == `RPC_OFF_CLOCK_RECOVERY)
      next_rdata = clock_recovery_config;
    else if (reg_addr_in == `RPC_OFF_GAIN_TIMING)
      next_rdata = gain_control_timing;
    else if (reg_addr_in == `RPC_OFF_GAIN_THRESHOLDS)
      next_rdata = gain_control_thresholds;
    else if (reg_addr_in == `RPC_OFF_GAIN_ENABLE)
      next_rdata = gain_control_enable;
    else if (reg_addr_in == `RPC_OFF_ANTENNA_SWITCH)
      next_rdata = antenna_switch_config;
    else if (reg_addr_in == `RPC_OFF_BLOCK_STATUS)
      next_rdata = block_status;
    else if (reg_addr_in == `RPC_OFF_FIELD_LENGTHS)
      next_rdata = packet_field_lengths;
    else if (reg_addr_in == `RPC_OFF_FORMAT_SELECT)
      next_rdata = packet_format_select;
    else if (reg_addr_in == `RPC_OFF_PREAMBLE_SYNC)
      next_rdata = preamble_sync_length;
    else if (reg_addr_in == `RPC_OFF_CODING_OPTIONS)
      next_rdata = packet_coding_options;
    else if (reg_addr_in == `RPC_OFF_LENGTH_HIGH)
      next_rdata = packet_length_high;
    else if (reg_addr_in == `RPC_OFF_LENGTH_LOW)
      next_rdata = packet_length_low;
    else if (reg_addr_in == `RPC_OFF_ALGO_SELECT)
      next_rdata = {4'h0, timing_recovery_algorithm, 3'h0};
  end

  // unmapped offsets read as zero; data held until the next read
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      reg_rdata_out <= 8'h00;
      reg_rdata_valid_out <= 1'b0;
    end
    else
    begin
      reg_rdata_valid_out <= reg_rd_in;
      if (reg_rd_in)
        reg_rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------
  // plain field views
  // ----------------------------------------
  assign recovery_proportional_gain_out =
    clock_recovery_config[`RPC_PGAIN_MSB:`RPC_PGAIN_LSB]; // [R1]
  assign timing_recovery_algorithm_out = timing_recovery_algorithm; // [R21]
  assign gain_measure_window_out = gain_control_timing[3:0];
  assign antenna_measure_window_out = antenna_switch_config[2:0]; // [R6]
  assign addr_field_bytes_out =
    packet_field_lengths[`RPC_ADDR_LEN_MSB:`RPC_ADDR_LEN_LSB]; // [R7]
  assign ctrl_field_bytes_out = packet_field_lengths[2:0]; // [R8]
  assign frame_format_code_out =
    packet_format_select[`RPC_FORMAT_MSB:`RPC_FORMAT_LSB]; // [R9]
  assign rx_route_select_out =
    packet_format_select[`RPC_RX_ROUTE_MSB:`RPC_RX_ROUTE_LSB]; // [R10]
  assign length_field_bits_out = packet_format_select[3:0]; // [R11]
  assign length_mode_select_out = preamble_sync_length[0]; // [R14]
  assign scrambler_on_out = packet_coding_options[`RPC_SCRAMBLER_BIT]; // [R16]
  assign transmit_source_select_out =
    packet_coding_options[`RPC_TX_SOURCE_MSB:`RPC_TX_SOURCE_LSB]; // [R17]
  assign error_correction_on_out = packet_coding_options[0]; // [R18]

  // ----------------------------------------
  // pn9 source
  // ----------------------------------------
  assign pn9_active = (transmit_source_select_out == `RPC_TX_SOURCE_PN9); // [R17]

  rpc_pn9 u_pn9 (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .enable_in(pn9_active),
    .step_in(tx_bit_strobe_in),
    .state_out(pn9_state)
  );

  // ----------------------------------------
  // derived, registered controls
  // ----------------------------------------
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      recovery_postfilter_span_out <= `RPC_POSTFILTER_LONG;
      recovery_integral_gain_out <= 4'h0;
      gain_control_on_out <= 1'b0;
      gain_above_high_out <= 1'b0;
      gain_below_low_out <= 1'b0;
      rx_fifo_write_out <= 1'b0;
      antenna_switch_on_out <= 1'b0;
      stacked_address_out <= 1'b0;
      frame_format_legal_out <= 1'b0;
      preamble_bytes_out <= 6'd0;
      sync_bytes_out <= 3'd0;
      crc_poly_out <= 24'h000000;
      crc_width_out <= 5'd0;
      pn9_bit_out <= 1'b0;
      packet_length_out <= 16'h0000;
    end
    else
    begin
      recovery_postfilter_span_out <= clock_recovery_config[`RPC_POSTFILTER_BIT] ?
        `RPC_POSTFILTER_LONG : `RPC_POSTFILTER_SHORT; // [R2]
      // dll mode has no integral path, so the gain is forced to zero
      recovery_integral_gain_out <= (timing_recovery_algorithm == `RPC_ALGO_PLL) ?
        clock_recovery_config[`RPC_IGAIN_MSB:`RPC_IGAIN_LSB] : 4'h0; // [R3] [R21]
      gain_control_on_out <= gain_control_enable[`RPC_GAIN_ON_BIT]; // [R4]
      gain_above_high_out <= gain_control_enable[`RPC_GAIN_ON_BIT] &&
        (gain_level_in > gain_control_thresholds[7:4]); // [R4]
      gain_below_low_out <= gain_control_enable[`RPC_GAIN_ON_BIT] &&
        (gain_level_in < gain_control_thresholds[3:0]); // [R4]
      rx_fifo_write_out <= rx_data_valid_in &&
        !(antenna_switch_config[`RPC_BLANKING_BIT] && below_carrier_sense_in); // [R5]
      antenna_switch_on_out <= antenna_switch_config[`RPC_ANT_ON_BIT]; // [R6]
      stacked_address_out <= (addr_field_bytes_out == 2'h2); // [R7]
      frame_format_legal_out <= (frame_format_code_out != 2'h1); // [R9]
      preamble_bytes_out <= {1'b0,
        preamble_sync_length[`RPC_PREAMBLE_MSB:`RPC_PREAMBLE_LSB]} + 6'd1; // [R12]
      sync_bytes_out <= {1'b0, preamble_sync_length[`RPC_SYNC_MSB:`RPC_SYNC_LSB]}
        + 3'd1; // [R13]
      crc_poly_out <= crc_poly_of(packet_coding_options[`RPC_CRC_MSB:`RPC_CRC_LSB]); // [R15]
      crc_width_out <= crc_width_of(packet_coding_options[`RPC_CRC_MSB:`RPC_CRC_LSB]); // [R15]
      // zero when the pn9 source is not selected
      pn9_bit_out <= pn9_active & pn9_state[0]; // [R17]
      packet_length_out <= {packet_length_high, packet_length_low}; // [R19] [R20]
    end
  end

endmodule

`default_nettype wire

//--- bench/rpc_config_regs_props.sv
`timescale 1ns/100ps
`default_nettype none

module rpc_config_regs_props (
  input wire sys_clk_in,
  input wire resetn_in,
  input wire [7:0] reg_addr_in,
  input wire reg_wr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_rd_in,
  input wire reg_rdata_valid_out,
  input wire [2:0] recovery_proportional_gain_out,
  input wire [4:0] recovery_postfilter_span_out,
  input wire [3:0] recovery_integral_gain_out,
  input wire timing_recovery_algorithm_out,
  input wire gain_control_on_out,
  input wire gain_above_high_out,
  input wire gain_below_low_out,
  input wire rx_data_valid_in,
  input wire below_carrier_sense_in,
  input wire rx_fifo_write_out,
  input wire [5:0] preamble_bytes_out,
  input wire [2:0] sync_bytes_out,
  input wire [23:0] crc_poly_out,
  input wire [1:0] transmit_source_select_out,
  input wire pn9_bit_out
);
  wire wr_clk = reg_wr_in && (reg_addr_in == 8'h23);
  wire wr_pre = reg_wr_in && (reg_addr_in == 8'h32);
  wire wr_crc = reg_wr_in && (reg_addr_in == 8'h33);

  function automatic [23:0] crc_poly_for(input [2:0] code);
    case (code)
      3'h1: crc_poly_for = 24'h000007;
      3'h2: crc_poly_for = 24'h008005;
      3'h3: crc_poly_for = 24'h001021;
      3'h4: crc_poly_for = 24'h864cbf;
      default: crc_poly_for = 24'h000000;
    endcase
  endfunction

  default clocking dcb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  // derived outputs lag a write by two edges, plain field views by one
  AST_READ_PULSE:
    assert property (reg_rd_in ##1 !reg_rd_in |-> reg_rdata_valid_out ##1 !reg_rdata_valid_out)
    else $error("read valid not a pulse");
  AST_PGAIN:
    assert property (wr_clk |=> recovery_proportional_gain_out == $past(reg_wdata_in[7:5]))
    else $error("pgain wrong");
  AST_POSTFILTER:
    assert property (wr_clk ##1 !wr_clk |=> recovery_postfilter_span_out ==
      ($past(reg_wdata_in[4], 2) ? 5'd16 : 5'd8))
    else $error("post-filter span wrong");
  AST_PLL_IGAIN:
    assert property ((wr_clk && !timing_recovery_algorithm_out) ##1
      (!wr_clk && !timing_recovery_algorithm_out) |=>
      recovery_integral_gain_out == $past(reg_wdata_in[3:0], 2))
    else $error("pll igain wrong");
  AST_DLL_IGAIN:
    assert property (timing_recovery_algorithm_out |=> recovery_integral_gain_out == 4'h0)
    else $error("dll igain not zero");
  AST_GAIN_GATE:
    assert property (!gain_control_on_out |-> !gain_above_high_out && !gain_below_low_out)
    else $error("gain compare while off");
  AST_BLANK_PASS:
    assert property (rx_data_valid_in && !below_carrier_sense_in |=> rx_fifo_write_out)
    else $error("unblanked data not written");
  AST_NO_DATA:
    assert property (!rx_data_valid_in |=> !rx_fifo_write_out)
    else $error("fifo write without data");
  AST_PREAMBLE_SYNC:
    assert property (wr_pre ##1 !wr_pre |=>
      preamble_bytes_out == {1'b0, $past(reg_wdata_in[7:3], 2)} + 6'd1 &&
      sync_bytes_out == {1'b0, $past(reg_wdata_in[2:1], 2)} + 3'd1)
    else $error("preamble or sync length wrong");
  AST_CRC_POLY:
    assert property (wr_crc ##1 !wr_crc |=>
      crc_poly_out == crc_poly_for($past(reg_wdata_in[7:5], 2)))
    else $error("crc polynomial wrong");
  AST_PN9_QUIET:
    assert property (transmit_source_select_out != 2'h3 |=> !pn9_bit_out)
    else $error("pn9 active off source");
endmodule

bind rpc_config_regs rpc_config_regs_props rpc_config_regs_props_inst (.*);

`default_nettype wire

//--- bench/rpc_config_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none

module rpc_config_regs_tb;
  logic sys_clk_in, resetn_in, reg_wr_in, reg_rd_in, reg_rdata_valid_out, tx_bit_strobe_in;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic [3:0] gain_level_in, recovery_integral_gain_out, gain_measure_window_out;
  logic [3:0] length_field_bits_out;
  logic below_carrier_sense_in, rx_data_valid_in, timing_recovery_algorithm_out;
  logic [2:0] recovery_proportional_gain_out, antenna_measure_window_out;
  logic [2:0] ctrl_field_bytes_out, sync_bytes_out;
  logic [4:0] recovery_postfilter_span_out, crc_width_out;
  logic gain_control_on_out, gain_above_high_out, gain_below_low_out, rx_fifo_write_out;
  logic antenna_switch_on_out, stacked_address_out, frame_format_legal_out;
  logic length_mode_select_out, scrambler_on_out, pn9_bit_out, error_correction_on_out;
  logic [1:0] addr_field_bytes_out, frame_format_code_out, rx_route_select_out;
  logic [1:0] transmit_source_select_out;
  logic [5:0] preamble_bytes_out;
  logic [23:0] crc_poly_out;
  logic [15:0] packet_length_out;
  int error_cnt = 0;
  int n_tests = 0;
  logic [7:0] offs [0:10] = '{8'h23,8'h24,8'h25,8'h26,8'h27,8'h30,8'h31,8'h32,8'h33,8'h34,8'h35};
  logic [7:0] rsts [0:10] = '{8'h58,8'h22,8'h65,8'h8a,8'h05,8'h00,8'h07,8'h1e,8'h20,8'h00,8'h14};
  logic [7:0] wmsk [0:10] = '{8'hff,8'h0f,8'hff,8'h80,8'h1f,8'h1f,8'hff,8'hff,8'hfd,8'hff,8'hff};
  logic [23:0] cpoly [0:5] = '{24'h0, 24'h7, 24'h8005, 24'h1021, 24'h864cbf, 24'h0};
  logic [4:0] cwid [0:5] = '{5'd0, 5'd8, 5'd16, 5'd16, 5'd24, 5'd0};

  rpc_config_regs rpc_config_regs_inst (
    .sys_clk_in, .resetn_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in,
    .reg_rdata_out, .reg_rdata_valid_out, .gain_level_in, .below_carrier_sense_in,
    .rx_data_valid_in, .tx_bit_strobe_in, .recovery_proportional_gain_out,
    .recovery_postfilter_span_out, .recovery_integral_gain_out, .timing_recovery_algorithm_out,
    .gain_measure_window_out, .gain_control_on_out, .gain_above_high_out, .gain_below_low_out,
    .rx_fifo_write_out, .antenna_switch_on_out, .antenna_measure_window_out,
    .addr_field_bytes_out, .stacked_address_out, .ctrl_field_bytes_out, .frame_format_code_out,
    .frame_format_legal_out, .rx_route_select_out, .length_field_bits_out, .preamble_bytes_out,
    .sync_bytes_out, .length_mode_select_out, .crc_poly_out, .crc_width_out, .scrambler_on_out,
    .transmit_source_select_out, .pn9_bit_out, .error_correction_on_out, .packet_length_out
  );

  always #10 sys_clk_in = ~sys_clk_in;

  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // sample 1 ns past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk({reg_rdata_valid_out, reg_rdata_out}, {1'b1, exp});
  endtask

  task automatic drive(input logic [3:0] lv, input logic v, input logic b);
    @(posedge sys_clk_in);
    gain_level_in <= lv;
    rx_data_valid_in <= v;
    below_carrier_sense_in <= b;
    tick(1);
  endtask

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_and_reserved;
    for (int i = 0; i < 11; i++)
    begin
      rd(offs[i], rsts[i]);
      wr(offs[i], 8'hff);
      rd(offs[i], wmsk[i] | rsts[i]);
      wr(offs[i], 8'h00);
      rd(offs[i], rsts[i] & ~wmsk[i]);
      wr(offs[i], rsts[i]);
    end
    wr(8'h50, 8'hff);
    rd(8'h50, 8'h00);
    tick(2);
    chk({recovery_postfilter_span_out, recovery_integral_gain_out}, {5'd16, 4'd8});
    chk({gain_control_on_out, antenna_switch_on_out, antenna_measure_window_out,
      gain_measure_window_out}, {5'h15, 4'h2});
    chk({crc_width_out, crc_poly_out, packet_length_out}, {5'd8, 24'h7, 16'h14});
  endtask

  task automatic t_recovery;
    rd(8'h1c, 8'h00);
    wr(8'h23, 8'hef);
    tick(2);
    chk({recovery_proportional_gain_out, recovery_postfilter_span_out}, {3'd7, 5'd8});
    chk(recovery_integral_gain_out, 4'hf);
    wr(8'h1c, 8'hff);
    tick(2);
    chk({timing_recovery_algorithm_out, recovery_integral_gain_out}, 5'h10);
    wr(8'h1c, 8'h00);
    wr(8'h23, 8'h58);
  endtask

  task automatic t_gain_and_blanking;
    wr(8'h25, 8'h96);
    drive(4'ha, 1'b1, 1'b1);
    chk({gain_above_high_out, gain_below_low_out, rx_fifo_write_out}, 3'h5);
    drive(4'h5, 1'b0, 1'b0);
    chk({gain_above_high_out, gain_below_low_out, rx_fifo_write_out}, 3'h2);
    drive(4'h9, 1'b1, 1'b0);
    chk({gain_above_high_out, gain_below_low_out}, 2'h0);
    wr(8'h26, 8'h00);
    wr(8'h27, 8'h1a);
    drive(4'ha, 1'b1, 1'b1);
    chk({gain_control_on_out, gain_above_high_out, rx_fifo_write_out}, 3'h0);
    chk({antenna_switch_on_out, antenna_measure_window_out}, 4'ha);
    drive(4'h0, 1'b1, 1'b0);
    chk(rx_fifo_write_out, 1'b1);
    rd(8'h2a, 8'h94);
    wr(8'h26, 8'h8a);
    wr(8'h25, 8'h65);
    wr(8'h27, 8'h05);
  endtask

  task automatic t_packet;
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h30, 8'(i * 9));
      wr(8'h31, 8'(i * 8'h55));
      tick(2);
      chk({addr_field_bytes_out, ctrl_field_bytes_out, stacked_address_out},
        {2'(i), 3'(i), i == 2});
      chk({frame_format_code_out, rx_route_select_out, length_field_bits_out},
        {2'(i), 2'(i), 4'(i * 5)});
      chk(frame_format_legal_out, i != 1);
    end
    wr(8'h32, 8'h00);
    tick(2);
    chk({preamble_bytes_out, sync_bytes_out, length_mode_select_out}, {6'd1, 3'd1, 1'b0});
    wr(8'h32, 8'hff);
    wr(8'h34, 8'ha5);
    wr(8'h35, 8'h3c);
    tick(2);
    chk({preamble_bytes_out, sync_bytes_out, length_mode_select_out}, {6'd32, 3'd4, 1'b1});
    chk(packet_length_out, 16'ha53c);
    for (int i = 5; i < 11; i++)
      wr(offs[i], rsts[i]);
  endtask

  task automatic t_coding;
    int ones;
    ones = 0;
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h33, 8'(i * 32));
      tick(2);
      chk({crc_width_out, crc_poly_out}, {cwid[i], cpoly[i]});
    end
    wr(8'h33, 8'h11);
    tick(2);
    chk({scrambler_on_out, transmit_source_select_out, error_correction_on_out}, 4'h9);
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h33, 8'(s * 4));
      tick(2);
      chk({scrambler_on_out, transmit_source_select_out, error_correction_on_out}, 4'(s * 2));
    end
    @(posedge sys_clk_in);
    tx_bit_strobe_in <= 1'b1;
    repeat (30)
    begin
      tick(1);
      if (pn9_bit_out === 1'b1)
        ones++;
    end
    @(posedge sys_clk_in);
    tx_bit_strobe_in <= 1'b0;
    chk({ones != 0, ones != 30}, 2'h3);
    wr(8'h33, 8'h08);
    tick(2);
    chk(pn9_bit_out, 1'b0);
    wr(8'h33, 8'h20);
  endtask

  initial
  begin
    sys_clk_in = 1'b0;
    resetn_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    gain_level_in = 4'h0;
    below_carrier_sense_in = 1'b0;
    rx_data_valid_in = 1'b0;
    tx_bit_strobe_in = 1'b0;
    repeat (20) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    t_reset_and_reserved;
    t_recovery;
    t_gain_and_blanking;
    t_packet;
    t_coding;
    test_done;
  end

  initial
  begin
    repeat (5000) @(posedge sys_clk_in);
    error_cnt++;
    test_done;
  end
endmodule

`default_nettype wire
